/* verilog/svint_defs.vh */
`ifndef SVINT_DEFS_VH
`define SVINT_DEFS_VH

// Register indices; the byte address is four times the index.
`define SVINT_IDX_CONFIG      8'h3E
`define SVINT_IDX_STATUS      8'h50
`define SVINT_IDX_CLEAR       8'h51
`define SVINT_IDX_ENABLE      8'h52
`define SVINT_IDX_REPEAT      8'h53

// Reset values.
`define SVINT_RST_CONFIG      8'hC5
`define SVINT_RST_ENABLE      3'h7
`define SVINT_RST_REPEAT      8'h23

// Field positions inside the configuration register.
`define SVINT_ACC_EN_BIT      7
`define SVINT_MAX_INT_HI      6
`define SVINT_MAX_INT_LO      4
`define SVINT_SLIDE_TIME_HI   3
`define SVINT_SLIDE_TIME_LO   2
`define SVINT_SCALE_HI        1
`define SVINT_SCALE_LO        0

// Event bits of the status, clear and enable registers.
`define SVINT_EV_SLIDER       0
`define SVINT_EV_REPEAT       1
`define SVINT_EV_EXTRA        2
`define SVINT_EV_W            3

// Slide-time limits in milliseconds.
`define SVINT_SLIDE_MS_0      10'd350
`define SVINT_SLIDE_MS_1      10'd560
`define SVINT_SLIDE_MS_2      10'd770
`define SVINT_SLIDE_MS_3      10'd980

// Repeat periods in measurement cycles.
`define SVINT_RPT_35          8'd35
`define SVINT_RPT_70          8'd70
`define SVINT_RPT_105         8'd105
`define SVINT_RPT_140         8'd140

// Timing: clock rate, millisecond base and speed window.
`define SVINT_CLK_HZ          125000000
`define SVINT_MS_PER_S        1000
`define SVINT_CLK_PER_MS      (`SVINT_CLK_HZ / `SVINT_MS_PER_S)
`define SVINT_SPEED_WIN_MS    7'd100
`define SVINT_SENS_SAT        3'd5

`endif

/* verilog/svint_top.v */
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "svint_defs.vh"

module svint_top #(
    parameter CLK_PER_MS = `SVINT_CLK_PER_MS
) (
    input  wire        I_CLK,
    input  wire        I_RST_N,
    input  wire        I_CE,
    input  wire        I_HSEL,
    input  wire [31:0] I_HADDR,
    input  wire [1:0]  I_HTRANS,
    input  wire        I_HWRITE,
    input  wire [2:0]  I_HSIZE,
    input  wire [31:0] I_HWDATA,
    input  wire        I_HREADY,
    input  wire        I_CYCLE_TICK,
    input  wire        I_SLIDE_ACTIVE,
    input  wire        I_SENSOR_STEP,
    input  wire        I_SLIDE_DONE,
    input  wire        I_SLIDER_EVENT,
    output reg  [31:0] O_HRDATA,
    output reg         O_HREADYOUT,
    output reg         O_HRESP,
    output reg         O_IRQ,
    output reg  [7:0]  O_REPEAT_PERIOD
);

    // Scaled repeat period from sensors per window, scaling code and normal period.
    function [7:0] scaled_period;
        input [2:0] sens;
        input [1:0] scale;
        input [7:0] normal;
        begin
            // Fewer than two sensors per window is not a fast slide and keeps the normal period.
            if (sens < 3'd2) begin
                scaled_period = normal;
            end else if (sens >= `SVINT_SENS_SAT) begin
                scaled_period = `SVINT_RPT_35;
            end else if (scale == 2'b11) begin
                // The 11b row is already fixed at 140, 105 and 70.
                case (sens)
                    3'd2:    scaled_period = `SVINT_RPT_140;
                    3'd3:    scaled_period = `SVINT_RPT_105;
                    default: scaled_period = `SVINT_RPT_70;
                endcase
            // Codes 10 and 01 step the period down as the slide speeds up.
            end else if (scale == 2'b10) begin
                case (sens)
                    3'd2:    scaled_period = `SVINT_RPT_105;
                    3'd3:    scaled_period = `SVINT_RPT_70;
                    default: scaled_period = `SVINT_RPT_35;
                endcase
            end else if (scale == 2'b01) begin
                scaled_period = (sens == 3'd2) ? `SVINT_RPT_70 : `SVINT_RPT_35;
            end else begin
                scaled_period = `SVINT_RPT_35;
            end
        end
    endfunction

    // Extra interrupt count from slide time, limit code and cap.
    function [2:0] extra_count;
        input [9:0] t_ms;
        input [1:0] limit_code;
        input [2:0] cap;
        reg   [9:0] limit;
        reg   [9:0] half;
        reg   [9:0] three_q;
        begin
            // Slide-time limit in milliseconds for the selected code.
            case (limit_code)
                2'd0:    limit = `SVINT_SLIDE_MS_0;
                2'd1:    limit = `SVINT_SLIDE_MS_1;
                2'd2:    limit = `SVINT_SLIDE_MS_2;
                default: limit = `SVINT_SLIDE_MS_3;
            endcase
            // The limits are whole milliseconds, so the three-quarter point rounds up; a slide
            // on the half or three-quarter edge falls into the slower band, one on the limit still counts.
            half    = limit >> 1;
            three_q = limit - (limit >> 2);
            if (t_ms > limit) begin
                extra_count = 3'd0;
            end else if (t_ms < half) begin
                extra_count = cap;
            end else if (t_ms < three_q) begin
                extra_count = cap >> 1;
            end else begin
                extra_count = {2'b00, cap[2]};
            end
        end
    endfunction

    // Software-visible registers and the bus data-phase state.
    // Only the configuration register is fixed by the device; the rest are local additions.
    reg  [7:0]               config_reg;
    reg  [7:0]               normal_period;
    reg  [`SVINT_EV_W-1:0]   status;
    reg  [`SVINT_EV_W-1:0]   irq_enable;
    reg                      dp_write;
    reg  [7:0]               dp_index;

    // Time base and speed measurement.
    reg  [16:0]              ms_cnt;
    reg                      ms_tick;
    reg  [6:0]               win_cnt;
    reg  [2:0]               win_sensors;
    reg  [2:0]               speed_sensors;

    // Slide timing and the interrupt generator.
    reg  [9:0]               slide_ms;
    reg                      active_d;
    reg  [7:0]               cyc_cnt;
    reg  [2:0]               extra_left;
    reg                      repeat_fire;
    reg                      extra_fire;

    // A transfer is taken only when the bus is ready and the slot is NONSEQ or SEQ.
    wire        addr_phase = I_HSEL && I_HREADY && I_HTRANS[1];
    wire [7:0]  addr_index = I_HADDR[9:2];
    wire        acc_en     = config_reg[`SVINT_ACC_EN_BIT];
    wire [2:0]  max_int    = config_reg[`SVINT_MAX_INT_HI:`SVINT_MAX_INT_LO];
    wire [1:0]  slide_code = config_reg[`SVINT_SLIDE_TIME_HI:`SVINT_SLIDE_TIME_LO];
    wire [1:0]  scale_code = config_reg[`SVINT_SCALE_HI:`SVINT_SCALE_LO];
    wire        slide_start = I_SLIDE_ACTIVE && !active_d;
    wire [7:0]  cur_period  = scaled_period(speed_sensors, scale_code, normal_period);
    wire        cyc_due     = (cyc_cnt + 8'd1 >= cur_period);
    wire        clear_wr    = dp_write && (dp_index == `SVINT_IDX_CLEAR);
    wire [`SVINT_EV_W-1:0] events = {extra_fire, repeat_fire, I_SLIDER_EVENT};

    // Next values of the software registers. The bus reads these rather than the flops,
    // so a read issued right behind a write to the same register returns the new word
    // instead of the one the write is about to replace.
    wire        wr_config   = dp_write && (dp_index == `SVINT_IDX_CONFIG);
    wire        wr_enable   = dp_write && (dp_index == `SVINT_IDX_ENABLE);
    wire        wr_repeat   = dp_write && (dp_index == `SVINT_IDX_REPEAT);
    wire [7:0]  next_config = wr_config ? I_HWDATA[7:0] : config_reg;
    wire [7:0]  next_repeat = wr_repeat ? I_HWDATA[7:0] : normal_period;
    wire [`SVINT_EV_W-1:0] next_enable = wr_enable ? I_HWDATA[`SVINT_EV_W-1:0] : irq_enable;

    // Set wins over clear: an event in the clearing cycle stays in status.
    wire [`SVINT_EV_W-1:0] clear_mask  = I_HWDATA[`SVINT_EV_W-1:0] & {`SVINT_EV_W{clear_wr}};
    wire [`SVINT_EV_W-1:0] next_status = (status & ~clear_mask) | events;

    // Bus slave: read data is captured in the address phase, writes land in the data phase.
    // Zero wait states, so the ready flop only leaves reset high; a frozen clock enable
    // would drop writes, so the bus must stay idle while I_CE is low.
    // Reads take the next-value wires, so a read right behind a write returns the new word.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            config_reg    <= `SVINT_RST_CONFIG;
            normal_period <= `SVINT_RST_REPEAT;
            irq_enable    <= `SVINT_RST_ENABLE;
            dp_write      <= 1'b0;
            dp_index      <= 8'h00;
            O_HRDATA      <= 32'h0000_0000;
            O_HREADYOUT   <= 1'b1;
            O_HRESP       <= 1'b0;
        end else if (I_CE) begin
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
            dp_write    <= addr_phase && I_HWRITE;
            dp_index    <= addr_index;
            config_reg    <= next_config;
            irq_enable    <= next_enable;
            normal_period <= next_repeat;
            if (addr_phase && !I_HWRITE) begin
                case (addr_index)
                    `SVINT_IDX_CONFIG: O_HRDATA <= {24'h00_0000, next_config};
                    `SVINT_IDX_STATUS: O_HRDATA <= {29'h0000_0000, next_status};
                    `SVINT_IDX_ENABLE: O_HRDATA <= {29'h0000_0000, next_enable};
                    `SVINT_IDX_REPEAT: O_HRDATA <= {24'h00_0000, next_repeat};
                    default:           O_HRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Millisecond time base; the divider is a parameter so simulation can shorten it.
    // The tick is registered so every consumer sees the same one-cycle pulse.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ms_cnt  <= 17'd0;
            ms_tick <= 1'b0;
        end else if (I_CE) begin
            ms_tick <= (ms_cnt == CLK_PER_MS[16:0] - 17'd1);
            if (ms_cnt >= CLK_PER_MS[16:0] - 17'd1) begin
                ms_cnt <= 17'd0;
            end else begin
                ms_cnt <= ms_cnt + 17'd1;
            end
        end
    end

    // Speed: sensors touched per 100 ms window, latched at each window end, saturating at five.
    // A step in the latching cycle opens the next window instead of being lost.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            win_cnt       <= 7'd0;
            win_sensors   <= 3'd0;
            speed_sensors <= 3'd0;
        end else if (I_CE) begin
            if (slide_start) begin
                win_cnt       <= 7'd0;
                win_sensors   <= {2'b00, I_SENSOR_STEP};
                speed_sensors <= 3'd0;
            end else if (ms_tick && win_cnt == `SVINT_SPEED_WIN_MS - 7'd1) begin
                win_cnt       <= 7'd0;
                speed_sensors <= win_sensors;
                win_sensors   <= {2'b00, I_SENSOR_STEP};
            end else begin
                if (ms_tick) begin
                    win_cnt <= win_cnt + 7'd1;
                end
                if (I_SENSOR_STEP && win_sensors < `SVINT_SENS_SAT) begin
                    win_sensors <= win_sensors + 3'd1;
                end
            end
        end
    end

    // Slide duration in ms; it saturates so a long slide never wraps into a fast one.
    // Counting stops when the touch lifts, so the end-of-slide strobe sees the final length.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            slide_ms <= 10'd0;
            active_d <= 1'b0;
        end else if (I_CE) begin
            active_d <= I_SLIDE_ACTIVE;
            if (slide_start) begin
                slide_ms <= 10'd0;
            end else if (I_SLIDE_ACTIVE && ms_tick && slide_ms != 10'h3FF) begin
                slide_ms <= slide_ms + 10'd1;
            end
        end
    end

    // Repeat and extra interrupts share one measurement-cycle counter: repeats run only
    // while the touch is down, extras only after the slide is done.
    // A new slide start wins over everything, so extras left from the last slide are dropped.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cyc_cnt         <= 8'd0;
            extra_left      <= 3'd0;
            repeat_fire     <= 1'b0;
            extra_fire      <= 1'b0;
            O_REPEAT_PERIOD <= `SVINT_RST_REPEAT;
        end else if (I_CE) begin
            repeat_fire     <= 1'b0;
            extra_fire      <= 1'b0;
            O_REPEAT_PERIOD <= cur_period;
            if (slide_start) begin
                cyc_cnt    <= 8'd0;
                extra_left <= 3'd0;
            // The count is fixed once, at the end of the slide, from the settings then in force.
            end else if (I_SLIDE_DONE) begin
                cyc_cnt <= 8'd0;
                if (acc_en) begin
                    extra_left <= extra_count(slide_ms, slide_code, max_int);
                end else begin
                    extra_left <= 3'd0;
                end
            end else if (I_CYCLE_TICK && (I_SLIDE_ACTIVE || extra_left != 3'd0)) begin
                if (cyc_due) begin
                    cyc_cnt <= 8'd0;
                    if (I_SLIDE_ACTIVE) begin
                        repeat_fire <= 1'b1;
                    end else begin
                        extra_fire <= 1'b1;
                        extra_left <= extra_left - 3'd1;
                    end
                end else begin
                    cyc_cnt <= cyc_cnt + 8'd1;
                end
            end
        end
    end

    // Sticky status with write-one-to-clear; a new event in the clearing cycle wins.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            status <= {`SVINT_EV_W{1'b0}};
            O_IRQ  <= 1'b0;
        end else if (I_CE) begin
            status <= next_status;
            // The line follows status one cycle later, as every output leaves a flop.
            O_IRQ  <= |(status & irq_enable);
        end
    end

endmodule // svint_top

/* sim/svint_engine.sv */
`timescale 1ns/1ns

module svint_engine #(
    parameter DIV = 2
) (
    input  wire i_clk,
    input  wire i_rst_n,
    output reg  o_tick
);
    reg [7:0] cnt;

    // One tick per measurement cycle; a larger divider models a slower sampling engine.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt    <= 8'h00;
            o_tick <= 1'b0;
        end else begin
            cnt    <= (cnt == DIV - 1) ? 8'h00 : cnt + 8'h01;
            o_tick <= (cnt == DIV - 1);
        end
    end
endmodule // svint_engine

/* sim/svint_chk.sv */
`timescale 1ns/1ns
`include "svint_defs.vh"

module svint_chk #(
    parameter CLK_PER_MS = 10
) (
    input wire        I_CLK,
    input wire        I_RST_N,
    input wire        I_CE,
    input wire        I_HSEL,
    input wire [31:0] I_HADDR,
    input wire [1:0]  I_HTRANS,
    input wire        I_HWRITE,
    input wire [31:0] I_HWDATA,
    input wire        I_HREADY,
    input wire        I_SLIDER_EVENT,
    input wire [31:0] O_HRDATA,
    input wire        O_HREADYOUT,
    input wire        O_HRESP,
    input wire        O_IRQ,
    input wire [7:0]  O_REPEAT_PERIOD
);
    reg       rd_pend;
    reg       wr_pend;
    reg [7:0] idx;
    reg [7:0] cfg;
    reg [2:0] en;
    reg [7:0] nrm;

    // Shadow the bus so read data and masking can be predicted without the body.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rd_pend <= 1'b0;
            wr_pend <= 1'b0;
            idx     <= 8'h00;
            cfg     <= 8'hC5;
            en      <= 3'h7;
            nrm     <= 8'h23;
        end else if (I_CE) begin
            rd_pend <= I_HSEL & I_HREADY & I_HTRANS[1] & !I_HWRITE;
            wr_pend <= I_HSEL & I_HREADY & I_HTRANS[1] & I_HWRITE;
            idx     <= I_HADDR[9:2];
            if (wr_pend && idx == `SVINT_IDX_CONFIG) cfg <= I_HWDATA[7:0];
            if (wr_pend && idx == `SVINT_IDX_ENABLE) en <= I_HWDATA[2:0];
            if (wr_pend && idx == `SVINT_IDX_REPEAT) nrm <= I_HWDATA[7:0];
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    a_ready_high: assert property (O_HREADYOUT)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (!O_HRESP)
        else $error("slave gave an error response");
    a_cfg_readback: assert property (rd_pend && idx == `SVINT_IDX_CONFIG |->
        O_HRDATA == {24'h00_0000, cfg}) else $error("config read data wrong");
    a_upper_zero: assert property (rd_pend |-> O_HRDATA[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");
    a_unmapped_zero: assert property (rd_pend && idx < 8'h3E |-> O_HRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_slider_irq: assert property (I_SLIDER_EVENT && I_CE ##1 I_CE && en[0]
        |-> ##1 O_IRQ) else $error("slider event did not raise the interrupt");
    a_irq_masked: assert property (O_IRQ |-> $past(en) != 3'h0)
        else $error("interrupt high with all events masked");
    a_period_legal: assert property (O_REPEAT_PERIOD inside {`SVINT_RPT_35, `SVINT_RPT_70,
        `SVINT_RPT_105, `SVINT_RPT_140} || O_REPEAT_PERIOD == nrm || O_REPEAT_PERIOD == $past(nrm))
        else $error("repeat period outside the scaling table");
    a_period_reset: assert property ($rose(I_RST_N) |-> O_REPEAT_PERIOD == `SVINT_RPT_35)
        else $error("repeat period not normal after reset");

    c_cfg_read: cover property (rd_pend && idx == `SVINT_IDX_CONFIG);
    c_irq_rise: cover property ($rose(O_IRQ));
    c_period_max: cover property (O_REPEAT_PERIOD == `SVINT_RPT_140);
endmodule // svint_chk

bind svint_top svint_chk #(.CLK_PER_MS(CLK_PER_MS)) u_chk (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
    .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY),
    .I_SLIDER_EVENT(I_SLIDER_EVENT), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
    .O_HRESP(O_HRESP), .O_IRQ(O_IRQ), .O_REPEAT_PERIOD(O_REPEAT_PERIOD));

/* sim/slider_velocity_interrupts_bench.sv */
`timescale 1ns/1ns
`include "svint_defs.vh"

module slider_velocity_interrupts_bench;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0000_0000;
    reg  [1:0]  htrans = 2'b00;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0000_0000;
    reg         active = 1'b0;
    reg         step = 1'b0;
    reg         done = 1'b0;
    reg         sev = 1'b0;
    reg         ce = 1'b1;
    reg  [31:0] rd;
    wire [31:0] hrdata;
    wire        hready;
    wire        irq;
    wire        tick;
    wire [7:0]  period;
    integer     n_errors = 0;
    integer     tests_run = 0;
    integer     s;
    integer     k;

    svint_engine #(.DIV(2)) u_eng (.i_clk(clk), .i_rst_n(rst_n), .o_tick(tick));
    svint_top #(.CLK_PER_MS(10)) dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
        .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(3'b010), .I_HWDATA(hwdata), .I_HREADY(hready), .I_CYCLE_TICK(tick),
        .I_SLIDE_ACTIVE(active), .I_SENSOR_STEP(step), .I_SLIDE_DONE(done),
        .I_SLIDER_EVENT(sev), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(),
        .O_IRQ(irq), .O_REPEAT_PERIOD(period));

    // The 125 MHz clock.
    initial forever #4 clk = ~clk;

    task finish_test;
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask

    // One single transfer; entered just after an edge, read data taken at the data-phase edge.
    task ahb(input w, input [7:0] idx, input [31:0] d);
        hsel <= 1'b1;
        haddr <= {22'h00_0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        cyc(1);
        while (!hready) cyc(1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        cyc(1);
        while (!hready) cyc(1);
        rd = hrdata;
    endtask

    task t_regs;
        ahb(0, `SVINT_IDX_CONFIG, 0);
        chk(rd, 32'h0000_00C5);
        ahb(0, 8'h10, 0);
        chk(rd, 32'h0000_0000);
        ahb(1, `SVINT_IDX_CONFIG, 32'h0000_005A);
        ahb(0, `SVINT_IDX_CONFIG, 0);
        chk(rd, 32'h0000_005A);
    endtask

    // The status bit is sticky, so masking must hide it and unmasking bring it back.
    task t_irq;
        ahb(1, `SVINT_IDX_CLEAR, 32'h0000_0007);
        sev <= 1'b1;
        cyc(1);
        sev <= 1'b0;
        cyc(3);
        chk(irq, 1);
        ahb(1, `SVINT_IDX_ENABLE, 32'h0000_0006);
        cyc(2);
        chk(irq, 0);
        ahb(1, `SVINT_IDX_ENABLE, 32'h0000_0007);
        cyc(2);
        chk(irq, 1);
        ahb(1, `SVINT_IDX_CLEAR, 32'h0000_0001);
        cyc(2);
        chk(irq, 0);
    endtask

    // A low clock enable freezes every flop of svint_top (the engine keeps ticking), so the interrupt waits until it returns.
    task t_freeze;
        ahb(1, `SVINT_IDX_CLEAR, 32'h0000_0007);
        sev <= 1'b1;
        cyc(1);
        sev <= 1'b0;
        ce <= 1'b0;
        cyc(4);
        chk(irq, 0);
        ce <= 1'b1;
        cyc(2);
        chk(irq, 1);
        ahb(1, `SVINT_IDX_CLEAR, 32'h0000_0001);
        cyc(2);
        chk(irq, 0);
    endtask

    // A slide of ms milliseconds, then the extra interrupts are counted by polling status.
    task t_extra(input [7:0] cfg, input integer ms, input integer n);
        integer i;
        integer cnt;
        cnt = 0;
        ahb(1, `SVINT_IDX_CLEAR, 32'h0000_0007);
        ahb(1, `SVINT_IDX_CONFIG, {24'h00_0000, cfg});
        active <= 1'b1;
        cyc(ms * 10);
        done <= 1'b1;
        active <= 1'b0;
        cyc(1);
        done <= 1'b0;
        for (i = 0; i < 400; i = i + 1) begin
            ahb(0, `SVINT_IDX_STATUS, 0);
            if (rd[2]) begin
                cnt = cnt + 1;
                ahb(1, `SVINT_IDX_CLEAR, 32'h0000_0004);
            end
        end
        chk(cnt, n);
    endtask

    // Steps land early in the 100 ms window; the period is looked at after the window closes.
    task t_speed(input [1:0] sc, input integer ns);
        integer m;
        m = sc + 2 - ns;
        if (m < 0) m = 0;
        ahb(1, `SVINT_IDX_CONFIG, 32'h0000_00C4 | sc);
        active <= 1'b1;
        repeat (ns) begin
            step <= 1'b1;
            cyc(1);
            step <= 1'b0;
            cyc(1);
        end
        cyc(1100 - 2 * ns);
        chk(period, (ns < 2) ? 100 : 35 * (m + 1));
        active <= 1'b0;
        cyc(5);
    endtask

    // Reset for five cycles, then every scenario in turn.
    initial begin
        cyc(5);
        rst_n <= 1'b1;
        cyc(1);
        t_regs;
        t_irq;
        t_freeze;
        t_extra(8'hC5, 100, 4);
        t_extra(8'hC5, 350, 2);
        t_extra(8'hC5, 490, 1);
        t_extra(8'hC5, 600, 0);
        t_extra(8'h45, 100, 0);
        t_extra(8'hF1, 100, 7);
        t_extra(8'hF1, 200, 3);
        t_extra(8'hF1, 300, 1);
        t_extra(8'h85, 100, 0);
        t_extra(8'h95, 100, 1);
        t_extra(8'hB5, 350, 1);
        t_extra(8'hD5, 490, 1);
        t_extra(8'hE9, 600, 1);
        t_extra(8'hAD, 600, 1);
        ahb(1, `SVINT_IDX_REPEAT, 32'h0000_0064);
        for (s = 0; s < 4; s = s + 1)
            for (k = 1; k < 6; k = k + 1)
                t_speed(s[1:0], k);
        finish_test;
    end

    // The scenarios need about 80 000 cycles; a limit of 100 000 still leaves a margin.
    initial begin
        #800_000;
        n_errors = n_errors + 1;
        finish_test;
    end
endmodule // slider_velocity_interrupts_bench
